// ### inc/io_port_pkg.sv
`default_nettype none
package io_port_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 4;
    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] OFS_DATA = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_DIR = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_OPT = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_IOPT = 4'h3;
    // Field position of the global enable in the interrupt option register.
    localparam int GEN_BIT = 4;
    // Values after reset.
    localparam logic [PORT_W-1:0] RST_DATA = 8'h00;
    localparam logic [PORT_W-1:0] RST_DIR = 8'h00;
    localparam logic [PORT_W-1:0] RST_OPT = 8'h00;
    localparam logic RST_GEN = 1'b0;
    // Synchroniser depth in clock cycles.
    localparam int SYNC_STAGES = 2;

    typedef enum {
        MODE_IN_PULLUP,
        MODE_IN_FLOAT,
        MODE_IN_IRQ,
        MODE_IN_ANALOG,
        MODE_OUT_OD,
        MODE_OUT_PP
    } pin_mode_type;

    // Maps the direction, option and data bits of one pin to its mode.
    function automatic pin_mode_type pin_mode_of(input logic dir, input logic opt,
                                                 input logic dat);
        pin_mode_type m;
        m = MODE_IN_PULLUP;
        case ({dir, opt, dat})
            3'b000: m = MODE_IN_PULLUP;
            3'b001: m = MODE_IN_FLOAT;
            3'b010: m = MODE_IN_IRQ;
            3'b011: m = MODE_IN_ANALOG;
            3'b100, 3'b101: m = MODE_OUT_OD;
            default: m = MODE_OUT_PP;
        endcase
        return m;
    endfunction
endpackage
`default_nettype wire

// ### inc/pin_cfg_if.sv
`default_nettype none
interface pin_cfg_if #(parameter int W = 8);
    logic [W-1:0] dir;
    logic [W-1:0] opt;
    logic [W-1:0] dat;
    logic [W-1:0] pull_en;
    logic [W-1:0] irq_en;
    logic [W-1:0] ana_en;
    logic [W-1:0] drive_oe;
    logic [W-1:0] drive_val;
    logic [W-1:0] is_input;

    modport ctrl (
        output dir,
        output opt,
        output dat,
        input pull_en,
        input irq_en,
        input ana_en,
        input drive_oe,
        input drive_val,
        input is_input
    );
    modport dec (
        input dir,
        input opt,
        input dat,
        output pull_en,
        output irq_en,
        output ana_en,
        output drive_oe,
        output drive_val,
        output is_input
    );
endinterface
`default_nettype wire

// ### logic/pin_sync.sv
`default_nettype none
module pin_sync import io_port_pkg::*; #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_hold;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_meta = async_in;
        nxt_hold = meta_ff;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_ff <= '0;
            hold_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            hold_ff <= nxt_hold;
        end
    end

    assign sync_out = hold_ff;
endmodule
`default_nettype wire

// ### logic/pin_mode_decode.sv
`default_nettype none
module pin_mode_decode import io_port_pkg::*; #(
    parameter int W = 8,
    parameter logic [W-1:0] ANALOG_MASK = '1
) (
    // Configuration in, per-pin controls out
    pin_cfg_if.dec cfg
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            pin_mode_type m;
            assign m = pin_mode_of(cfg.dir[i], cfg.opt[i], cfg.dat[i]);
            assign cfg.pull_en[i] = (m == MODE_IN_PULLUP) || (m == MODE_IN_IRQ);
            assign cfg.irq_en[i] = (m == MODE_IN_IRQ);
            // Pins without an analog path simply float in this setting.
            assign cfg.ana_en[i] = (m == MODE_IN_ANALOG) && ANALOG_MASK[i];
            // Open drain only ever drives low; push-pull drives both levels.
            assign cfg.drive_oe[i] = (m == MODE_OUT_PP) ||
                                     ((m == MODE_OUT_OD) && !cfg.dat[i]);
            assign cfg.drive_val[i] = (m == MODE_OUT_PP) ? cfg.dat[i] : 1'b0;
            assign cfg.is_input[i] = !cfg.dir[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ### logic/io_port.sv
// Function
// - Direction, option, data all zero: digital input with pull-up, no interrupt.
// - Direction and option zero, data one: input without pull-up or interrupt.
// - Direction zero, option one, data zero: input with pull-up and interrupt.
// - Direction zero, option and data one: pin routed to analog converter.
// - Direction one, option zero: open-drain output whatever the data bit.
// - Direction and option one: push-pull output driving the latched data.
// - Reading data of an input pin returns the live pin level.
// - Writing data of an input pin updates the latch selecting its characteristics.
// - Wait state keeps port state; enabled pin interrupt wakes the device.
// - Stop state keeps port state; enabled pin interrupt ends it.
// - Pin interrupt needs interrupt configuration and the global enable set.
// - Reset clears all port registers: every pin input with pull-up.
// - Output pin: write sets the latch, read returns the stored latch.
// - Each register bit position controls the pin with the same index. Here the interrupt option register holds only the global enable, at bit 4.
//
// Design decisions made here: the address map and the plain strobed port.
`default_nettype none
module io_port import io_port_pkg::*; #(
    parameter int W = PORT_W,
    parameter logic [W-1:0] ANALOG_MASK = '1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pins
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pin_pullup,
    output logic [W-1:0] pin_analog,
    // Low-power state of the core
    input wire logic wait_mode,
    input wire logic stop_mode,
    // Toward the interrupt controller
    output logic ext_irq_req,
    output logic wake_req
);
    pin_cfg_if #(.W(W)) cfg ();

    logic [W-1:0] pin_sync_lvl;

    logic [W-1:0] pin_data_latch_ff;
    logic [W-1:0] dir_ff;
    logic [W-1:0] opt_ff;
    logic global_interrupt_enable_ff;
    logic [W-1:0] nxt_pin_data_latch;
    logic [W-1:0] nxt_dir;
    logic [W-1:0] nxt_opt;
    logic nxt_global_interrupt_enable;

    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    logic [W-1:0] pin_out_ff;
    logic [W-1:0] pin_oe_ff;
    logic [W-1:0] pin_pullup_ff;
    logic [W-1:0] pin_analog_ff;
    logic irq_ff;
    logic wake_ff;
    logic [W-1:0] nxt_pin_out;
    logic [W-1:0] nxt_pin_oe;
    logic [W-1:0] nxt_pin_pullup;
    logic [W-1:0] nxt_pin_analog;
    logic nxt_irq;
    logic nxt_wake;

    logic [W-1:0] data_view;
    logic [7:0] data_word;
    logic [7:0] dir_word;
    logic [7:0] opt_word;
    logic [7:0] iopt_word;

    pin_sync #(
        .W(W)
    ) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .async_in(pin_in),
        .sync_out(pin_sync_lvl)
    );

    pin_mode_decode #(
        .W(W),
        .ANALOG_MASK(ANALOG_MASK)
    ) u_decode (
        .cfg(cfg.dec)
    );

    assign cfg.dir = dir_ff;
    assign cfg.opt = opt_ff;
    assign cfg.dat = pin_data_latch_ff;

    // Configuration registers. Low-power inputs do not touch them, so the
    // port keeps its state through wait and stop.
    always_comb begin
        nxt_pin_data_latch = pin_data_latch_ff;
        nxt_dir = dir_ff;
        nxt_opt = opt_ff;
        nxt_global_interrupt_enable = global_interrupt_enable_ff;
        if (reg_wr) begin
            case (reg_addr)
                OFS_DATA: nxt_pin_data_latch = reg_wdata[W-1:0];
                OFS_DIR: nxt_dir = reg_wdata[W-1:0];
                OFS_OPT: nxt_opt = reg_wdata[W-1:0];
                OFS_IOPT: nxt_global_interrupt_enable = reg_wdata[GEN_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_data_latch_ff <= RST_DATA;
            dir_ff <= RST_DIR;
            opt_ff <= RST_OPT;
            global_interrupt_enable_ff <= RST_GEN;
        end else begin
            pin_data_latch_ff <= nxt_pin_data_latch;
            dir_ff <= nxt_dir;
            opt_ff <= nxt_opt;
            global_interrupt_enable_ff <= nxt_global_interrupt_enable;
        end
    end

    // Input pins show their live level and output pins their latch. A
    // read-modify-write of this view would rewrite input characteristics.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            data_view[i] = cfg.is_input[i] ? pin_sync_lvl[i]
                                           : pin_data_latch_ff[i];
        end
    end

    // Bits above a narrow port read as zero.
    always_comb begin
        data_word = '0;
        dir_word = '0;
        opt_word = '0;
        iopt_word = '0;
        data_word[W-1:0] = data_view;
        dir_word[W-1:0] = dir_ff;
        opt_word[W-1:0] = opt_ff;
        iopt_word[GEN_BIT] = global_interrupt_enable_ff;
    end

    // Read data stand for exactly the cycle after the strobe.
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_DATA: nxt_rdata = data_word;
                OFS_DIR: nxt_rdata = dir_word;
                OFS_OPT: nxt_rdata = opt_word;
                OFS_IOPT: nxt_rdata = iopt_word;
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Pin drive and the combined request. Every pin output is registered,
    // which costs one cycle after a register write.
    always_comb begin
        nxt_pin_out = cfg.drive_val;
        nxt_pin_oe = cfg.drive_oe;
        nxt_pin_pullup = cfg.pull_en;
        nxt_pin_analog = cfg.ana_en;
        // A low level on any interrupt pin raises the request while the global
        // enable is set; edge or level selection is left to the interrupt controller.
        nxt_irq = global_interrupt_enable_ff &&
                  |(cfg.irq_en & ~pin_sync_lvl);
        nxt_wake = nxt_irq && (wait_mode || stop_mode);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
            pin_pullup_ff <= '1;
            pin_analog_ff <= '0;
            irq_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            pin_pullup_ff <= nxt_pin_pullup;
            pin_analog_ff <= nxt_pin_analog;
            irq_ff <= nxt_irq;
            wake_ff <= nxt_wake;
        end
    end

    assign reg_rdata = rdata_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign pin_pullup = pin_pullup_ff;
    assign pin_analog = pin_analog_ff;
    assign ext_irq_req = irq_ff;
    assign wake_req = wake_ff;
endmodule
`default_nettype wire

// ### verif/io_port_chk.sv
`default_nettype none
module io_port_chk import io_port_pkg::*; #(
    parameter int W = PORT_W
) (
    // Clock, reset and register port
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins, low power and request
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pin_pullup,
    input wire logic [W-1:0] pin_analog,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic ext_irq_req,
    input wire logic wake_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    rst_state_a: assert property ($fell(srst) |-> pin_oe == '0 && pin_pullup == '1)
        else $error("pins not in reset state");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    rd_unmapped_a: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    out_driven_a: assert property ((pin_out & ~pin_oe) == '0)
        else $error("drive value on a released pin");
    analog_pull_a: assert property ((pin_analog & (pin_pullup | pin_oe)) == '0)
        else $error("analog pin pulled or driven");
    wake_cause_a: assert property (
        wake_req |-> ext_irq_req && $past(wait_mode || stop_mode))
        else $error("wake without cause");
    low_hold_a: assert property (
        (wait_mode || stop_mode) && !reg_wr && !$past(reg_wr)
        |=> $stable(pin_oe) && $stable(pin_out) && $stable(pin_pullup))
        else $error("pins moved in low power");
    irq_cause_a: assert property ($rose(ext_irq_req) |-> ~&$past(pin_in, 3))
        else $error("request without low pin");
    cover property (wake_req);
    cover property ($rose(ext_irq_req));
    cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind io_port io_port_chk #(.W(W)) i_io_port_chk (.clk_sys, .srst, .reg_addr, .reg_wr,
    .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_analog,
    .wait_mode, .stop_mode, .ext_irq_req, .wake_req);
`default_nettype wire

// ### verif/board_model.sv
`default_nettype none
module board_model import io_port_pkg::*; (
    // Clock
    input wire logic clk_sys,
    // Device pad controls and board drive
    input wire logic [PORT_W-1:0] pin_out,
    input wire logic [PORT_W-1:0] pin_oe,
    input wire logic [PORT_W-1:0] pin_pullup,
    input wire logic [PORT_W-1:0] ext_en,
    input wire logic [PORT_W-1:0] ext_val,
    // Resolved pad level
    output logic [PORT_W-1:0] pin_in
);
    logic [PORT_W-1:0] tog_ff = '0;
    // An undriven pad without pull-up toggles, so a stale level never looks valid.
    always_ff @(posedge clk_sys) tog_ff <= ~tog_ff;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | tog_ff));
endmodule
`default_nettype wire

// ### verif/tb_configurable_io_port.sv
`default_nettype none
module tb_configurable_io_port import io_port_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, srst, reg_wr, reg_rd, wait_mode, stop_mode, ext_irq_req, wake_req;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [PORT_W-1:0] pin_in, pin_out, pin_oe, pin_pullup, pin_analog, ext_en, ext_val;
    int errors, n_checks;
    io_port i_io_port (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_analog,
        .wait_mode, .stop_mode, .ext_irq_req, .wake_req);
    board_model i_board_model (.clk_sys, .pin_out, .pin_oe, .pin_pullup, .ext_en,
        .ext_val, .pin_in);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_reset();
        settle(2);
        chk(pin_pullup, 8'hFF);
        chk(pin_oe, 8'h00);
        chk(pin_analog, 8'h00);
        rd(OFS_DIR, 8'h00);
        rd(OFS_IOPT, 8'h00);
        rd(OFS_DATA, 8'hF5);
    endtask
    // Pins 0 to 4 get modes 0 to 4, pin 5 open drain, pins 6 and 7 push-pull; whole-register writes keep away from irq to analog hops.
    task automatic t_modes();
        wr(OFS_DATA, 8'hAA);
        wr(OFS_OPT, 8'hCC);
        wr(OFS_DIR, 8'hF0);
        settle(3);
        chk(pin_pullup, 8'h05);
        chk(pin_analog, 8'h08);
        chk(pin_oe, 8'hD0);
        chk(pin_out, 8'h80);
        rd(OFS_DATA, 8'hA5);
        wr(OFS_DATA, 8'h08);
        settle(3);
        chk(pin_pullup, 8'h07);
        chk(pin_analog, 8'h08);
        chk(pin_oe, 8'hF0);
        chk(pin_out, 8'h00);
    endtask
    task automatic t_irq();
        @(posedge clk_sys);
        ext_val <= 8'h00;
        settle(5);
        chk({7'h00, ext_irq_req}, 8'h00);
        wr(OFS_IOPT, 8'hFF);
        rd(OFS_IOPT, 8'h10);
        settle(4);
        chk({7'h00, ext_irq_req}, 8'h01);
        @(posedge clk_sys);
        ext_val <= 8'h04;
        settle(5);
        chk({7'h00, ext_irq_req}, 8'h00);
        @(posedge clk_sys);
        ext_val <= 8'h00;
        settle(5);
        chk({7'h00, ext_irq_req}, 8'h01);
    endtask
    task automatic t_low();
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_sys);
            wait_mode <= (m == 0);
            stop_mode <= (m == 1);
            settle(3);
            chk({7'h00, wake_req}, 8'h01);
            chk(pin_oe, 8'hF0);
            rd(OFS_DIR, 8'hF0);
            @(posedge clk_sys);
            wait_mode <= 1'b0;
            stop_mode <= 1'b0;
            settle(3);
            chk({7'h00, wake_req}, 8'h00);
        end
    endtask
    task automatic t_unmapped();
        wr(4'h7, 8'h55);
        rd(4'h7, 8'h00);
        rd(OFS_OPT, 8'hCC);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        finish_test();
    end
    initial begin
        srst = 1'b1;
        {reg_wr, reg_rd, wait_mode, stop_mode} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        ext_en = 8'h0F;
        ext_val = 8'h05;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_modes();
        t_irq();
        t_low();
        t_unmapped();
        finish_test();
    end
endmodule
`default_nettype wire
